// File: rtl/pwm_panel_pkg.sv
// Purpose: constants shared by the dual pwm and panel enable block
// Assumes: byte-wide registers, one system clock at 100 MHz
// Notes: oscillator rate is reproduced by a fractional tick from mclk_i
package pwm_panel_pkg;
    localparam logic [7:0] OFS_PWM0_DIV = 8'h4B;
    localparam logic [7:0] OFS_PWM1_DIV = 8'h4C;
    localparam logic [7:0] OFS_PWM1_DUTY = 8'h4D;
    localparam logic [7:0] OFS_PWM0_DUTY = 8'h4E;
    localparam logic [7:0] OFS_BACKLIGHT = 8'h51;
    localparam logic [7:0] OFS_PANEL = 8'h52;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] RST_OFS = 8'h00;
    localparam int ENABLE_BIT = 7;
    localparam int PIN_BIT = 0;
    localparam logic [7:0] DUTY_WRAP = 8'hFF;
    localparam logic [7:0] DUTY_ZERO = 8'h00;
    localparam logic [6:0] PRE_ZERO = 7'h00;
    localparam int MCLK_MHZ = 100;
    localparam int OSC_MHZ = 6;
    localparam logic [6:0] ACC_STEP = 7'(OSC_MHZ);
    localparam logic [6:0] ACC_WRAP = 7'(MCLK_MHZ);
    localparam logic [6:0] ACC_ZERO = 7'h00;
endpackage

// File: rtl/dual_pwm_and_panel_enables.sv
// Purpose: two pwm channels plus backlight and panel enable pins
// Assumes: register port is the byte side of the serial management slave
// Notes: duty uses the comparator form, high while count is below threshold
`timescale 1ns/1ns

module pwm_channel (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic tick_i,
    input wire logic [7:0] ctrl_i,
    input wire logic [7:0] duty_i,
    output logic pwm_o
);
    logic en_s, next_en_s;
    logic [6:0] div_s, next_div_s;
    logic [7:0] duty_s, next_duty_s;
    logic [6:0] pre_cnt, next_pre_cnt;
    logic [7:0] duty_cnt, next_duty_cnt;
    logic [7:0] duty_act, next_duty_act;
    logic next_pwm;

    always_comb begin
        next_en_s = en_s;
        next_div_s = div_s;
        next_duty_s = duty_s;
        next_pre_cnt = pre_cnt;
        next_duty_cnt = duty_cnt;
        next_duty_act = duty_act;
        // settings cross into the oscillator timebase only on its tick
        if (tick_i) begin
            next_en_s = ctrl_i[pwm_panel_pkg::ENABLE_BIT];
            next_div_s = ctrl_i[6:0];
            next_duty_s = duty_i;
        end
        if (!en_s) begin
            next_pre_cnt = pwm_panel_pkg::PRE_ZERO;
            next_duty_cnt = pwm_panel_pkg::DUTY_ZERO;
            // disabled: threshold passes straight through so the first period after enable is whole
            next_duty_act = duty_s;
        end else if (tick_i) begin
            if (pre_cnt >= div_s) begin
                // zero divider lands here every tick, bypassing the prescaler
                next_pre_cnt = pwm_panel_pkg::PRE_ZERO;
                next_duty_cnt = duty_cnt + 8'h01;
                if (duty_cnt == pwm_panel_pkg::DUTY_WRAP) begin
                    next_duty_act = duty_s;
                end
            end else begin
                next_pre_cnt = pre_cnt + 7'h01;
            end
        end
        // comparator form: 0x00 never goes high, 0xFF leaves one low count per period
        next_pwm = en_s && (duty_cnt < duty_act);
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_s <= 1'b0;
            div_s <= pwm_panel_pkg::PRE_ZERO;
            duty_s <= pwm_panel_pkg::DUTY_ZERO;
            pre_cnt <= pwm_panel_pkg::PRE_ZERO;
            duty_cnt <= pwm_panel_pkg::DUTY_ZERO;
            duty_act <= pwm_panel_pkg::DUTY_ZERO;
            pwm_o <= 1'b0;
        end else begin
            en_s <= next_en_s;
            div_s <= next_div_s;
            duty_s <= next_duty_s;
            pre_cnt <= next_pre_cnt;
            duty_cnt <= next_duty_cnt;
            duty_act <= next_duty_act;
            pwm_o <= next_pwm;
        end
    end
endmodule

// Summary of operation
// - Two independent pwm channels cover about 183 Hz to 23.4 kHz with 1/256 duty steps.
// - Both channels count on a 6 MHz oscillator timebase, not on the host bus timing.
// - The 7-bit prescaler counts 0 to the divider value, so the tick rate is base over divider plus one.
// - A divider of zero passes the base tick straight through.
// - The 8-bit duty counter runs 0x00 to 0xFF and wraps, 256 prescaled ticks per period.
// - Output is high while the duty counter is below the threshold and low otherwise.
// - The table's plus-one duty form conflicts with the comparator; the comparator form is used.
// - Bit 7 of each divider register enables its channel and resets to 0.
// - Duty writes are taken while the channel runs, without disabling it.
// - Bit 0 of the backlight register drives the backlight enable pin.
// - Bit 0 of the panel register drives the panel enable pin.
// - After reset both enable pins are low and their registers are zero.
// - A read returns the register at the offset last written, in a combined transfer.
module dual_pwm_and_panel_enables (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic reg_ofs_wr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_data_i,
    output logic [7:0] reg_rdata_o,
    output logic pwm0_o,
    output logic pwm1_o,
    output logic backlight_enable_pin_o,
    output logic panel_enable_pin_o
);
    logic [7:0] reg_ofs, next_reg_ofs;
    logic [7:0] pwm0_divider_ctrl, next_pwm0_divider_ctrl;
    logic [7:0] pwm1_divider_ctrl, next_pwm1_divider_ctrl;
    logic [7:0] pwm0_duty_threshold, next_pwm0_duty_threshold;
    logic [7:0] pwm1_duty_threshold, next_pwm1_duty_threshold;
    logic [7:0] backlight_enable_out, next_backlight_enable_out;
    logic [7:0] panel_enable_out, next_panel_enable_out;
    logic [7:0] next_rdata;
    logic next_backlight_pin, next_panel_pin;
    logic [6:0] osc_acc, next_osc_acc;
    logic osc_tick, next_osc_tick;
    logic [7:0] read_mux;

    // fractional accumulator gives an average 6 MHz tick, with 16/17-cycle jitter
    always_comb begin
        next_osc_tick = 1'b0;
        next_osc_acc = osc_acc + pwm_panel_pkg::ACC_STEP;
        if (next_osc_acc >= pwm_panel_pkg::ACC_WRAP) begin
            next_osc_acc = next_osc_acc - pwm_panel_pkg::ACC_WRAP;
            next_osc_tick = 1'b1;
        end
    end

    always_comb begin
        case (reg_ofs)
            pwm_panel_pkg::OFS_PWM0_DIV: read_mux = pwm0_divider_ctrl;
            pwm_panel_pkg::OFS_PWM1_DIV: read_mux = pwm1_divider_ctrl;
            pwm_panel_pkg::OFS_PWM0_DUTY: read_mux = pwm0_duty_threshold;
            pwm_panel_pkg::OFS_PWM1_DUTY: read_mux = pwm1_duty_threshold;
            pwm_panel_pkg::OFS_BACKLIGHT: read_mux = backlight_enable_out;
            pwm_panel_pkg::OFS_PANEL: read_mux = panel_enable_out;
            // unmapped offsets read as zero so a burst across gaps stays harmless
            default: read_mux = pwm_panel_pkg::RST_REG;
        endcase
    end

    always_comb begin
        next_reg_ofs = reg_ofs;
        next_pwm0_divider_ctrl = pwm0_divider_ctrl;
        next_pwm1_divider_ctrl = pwm1_divider_ctrl;
        next_pwm0_duty_threshold = pwm0_duty_threshold;
        next_pwm1_duty_threshold = pwm1_duty_threshold;
        next_backlight_enable_out = backlight_enable_out;
        next_panel_enable_out = panel_enable_out;
        next_rdata = reg_rdata_o;
        if (reg_ofs_wr_i) begin
            next_reg_ofs = reg_data_i;
        end else if (reg_rd_i) begin
            next_rdata = read_mux;
            next_reg_ofs = reg_ofs + 8'h01;
        end else if (reg_wr_i) begin
            next_reg_ofs = reg_ofs + 8'h01;
            case (reg_ofs)
                pwm_panel_pkg::OFS_PWM0_DIV: next_pwm0_divider_ctrl = reg_data_i;
                pwm_panel_pkg::OFS_PWM1_DIV: next_pwm1_divider_ctrl = reg_data_i;
                pwm_panel_pkg::OFS_PWM0_DUTY: next_pwm0_duty_threshold = reg_data_i;
                pwm_panel_pkg::OFS_PWM1_DUTY: next_pwm1_duty_threshold = reg_data_i;
                pwm_panel_pkg::OFS_BACKLIGHT: next_backlight_enable_out = {7'h00, reg_data_i[0]};
                pwm_panel_pkg::OFS_PANEL: next_panel_enable_out = {7'h00, reg_data_i[0]};
                default: next_reg_ofs = reg_ofs + 8'h01;
            endcase
        end
        next_backlight_pin = backlight_enable_out[pwm_panel_pkg::PIN_BIT];
        next_panel_pin = panel_enable_out[pwm_panel_pkg::PIN_BIT];
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_ofs <= pwm_panel_pkg::RST_OFS;
            pwm0_divider_ctrl <= pwm_panel_pkg::RST_REG;
            pwm1_divider_ctrl <= pwm_panel_pkg::RST_REG;
            pwm0_duty_threshold <= pwm_panel_pkg::RST_REG;
            pwm1_duty_threshold <= pwm_panel_pkg::RST_REG;
            backlight_enable_out <= pwm_panel_pkg::RST_REG;
            panel_enable_out <= pwm_panel_pkg::RST_REG;
            reg_rdata_o <= pwm_panel_pkg::RST_REG;
            backlight_enable_pin_o <= 1'b0;
            panel_enable_pin_o <= 1'b0;
            osc_acc <= pwm_panel_pkg::ACC_ZERO;
            osc_tick <= 1'b0;
        end else begin
            reg_ofs <= next_reg_ofs;
            pwm0_divider_ctrl <= next_pwm0_divider_ctrl;
            pwm1_divider_ctrl <= next_pwm1_divider_ctrl;
            pwm0_duty_threshold <= next_pwm0_duty_threshold;
            pwm1_duty_threshold <= next_pwm1_duty_threshold;
            backlight_enable_out <= next_backlight_enable_out;
            panel_enable_out <= next_panel_enable_out;
            reg_rdata_o <= next_rdata;
            backlight_enable_pin_o <= next_backlight_pin;
            panel_enable_pin_o <= next_panel_pin;
            osc_acc <= next_osc_acc;
            osc_tick <= next_osc_tick;
        end
    end

    // divider changes on a running channel are not guarded; software disables first
    pwm_channel u_pwm0 (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .tick_i(osc_tick),
        .ctrl_i(pwm0_divider_ctrl),
        .duty_i(pwm0_duty_threshold),
        .pwm_o(pwm0_o)
    );

    pwm_channel u_pwm1 (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .tick_i(osc_tick),
        .ctrl_i(pwm1_divider_ctrl),
        .duty_i(pwm1_duty_threshold),
        .pwm_o(pwm1_o)
    );
endmodule

// File: bench/pwm_probe.sv
// Purpose: far-side load that times each pwm pulse train
// Assumes: pwm_i is a registered level from the block
// Notes: the first period after any change is partial, so skip it
`timescale 1ns/1ns
module pwm_probe (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic pwm_i,
    output logic [15:0] hi_o,
    output logic [15:0] per_o,
    output logic [7:0] rises_o
);
    logic [15:0] hi_c, per_c;
    logic prev;
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {hi_c, per_c, hi_o, per_o, rises_o, prev} <= '0;
        end else begin
            prev <= pwm_i;
            if (pwm_i && !prev) begin
                hi_o <= hi_c;
                per_o <= per_c;
                hi_c <= 16'h0001;
                per_c <= 16'h0001;
                rises_o <= rises_o + 8'h01;
            end else begin
                per_c <= per_c + 16'h0001;
                hi_c <= hi_c + {15'h0000, pwm_i};
            end
        end
    end
endmodule

// File: bench/pwm_panel_props.sv
// Purpose: port checker for the pwm and panel block
// Assumes: pointer mirror follows the burst offset rule
// Notes: pwm timing is checked loosely here, counts within 8 cycles in the bench
`timescale 1ns/1ns
module pwm_panel_props (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic reg_ofs_wr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_data_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic pwm0_o,
    input wire logic pwm1_o,
    input wire logic backlight_enable_pin_o,
    input wire logic panel_enable_pin_o
);
    logic [7:0] ptr, duty0;
    logic en0, wr_ok, rd_ok;
    assign wr_ok = reg_wr_i && !reg_ofs_wr_i && !reg_rd_i;
    assign rd_ok = reg_rd_i && !reg_ofs_wr_i;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ptr <= 8'h00;
            duty0 <= 8'h00;
            en0 <= 1'b0;
        end else if (reg_ofs_wr_i) begin
            ptr <= reg_data_i;
        end else if (reg_rd_i || reg_wr_i) begin
            ptr <= ptr + 8'h01;
            if (wr_ok && ptr == 8'h4B) en0 <= reg_data_i[7];
            if (wr_ok && ptr == 8'h4E) duty0 <= reg_data_i;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    a_backlight_follow: assert property (wr_ok && ptr == 8'h51 |-> ##2
        backlight_enable_pin_o == $past(reg_data_i[0], 2)) else $error("backlight pin off");
    a_panel_follow: assert property (wr_ok && ptr == 8'h52 |-> ##2
        panel_enable_pin_o == $past(reg_data_i[0], 2)) else $error("panel pin off");
    a_unmapped_reads_zero: assert property (rd_ok && !(ptr inside {8'h4B, 8'h4C, 8'h4D, 8'h4E,
        8'h51, 8'h52}) |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    a_reserved_bits_zero: assert property (rd_ok && (ptr == 8'h51 || ptr == 8'h52)
        |=> reg_rdata_o[7:1] == 7'h00) else $error("reserved bits set");
    a_read_matches_pin: assert property (rd_ok && ptr == 8'h51
        |=> reg_rdata_o[0] == backlight_enable_pin_o) else $error("readback differs from pin");
    a_rdata_holds: assert property (!rd_ok |=> $stable(reg_rdata_o)) else $error("rdata moved");
    // one tick of grace because enable is sampled only on the oscillator tick
    a_off_no_rise: assert property ($rose(pwm0_o) |-> en0 || $past(en0, 20)) else $error("disabled pwm rose");
    a_duty_zero_low: assert property ($rose(pwm0_o) |-> duty0 != 8'h00) else $error("zero duty pulsed");
    a_pulse_whole: assert property ($rose(pwm1_o) |-> pwm1_o [*8]) else $error("runt pulse");
endmodule
bind dual_pwm_and_panel_enables pwm_panel_props chk_u (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .reg_ofs_wr_i(reg_ofs_wr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_data_i(reg_data_i),
    .reg_rdata_o(reg_rdata_o), .pwm0_o(pwm0_o), .pwm1_o(pwm1_o),
    .backlight_enable_pin_o(backlight_enable_pin_o), .panel_enable_pin_o(panel_enable_pin_o));

// File: bench/dual_pwm_and_panel_enables_tb.sv
// Purpose: register-driven test of the pwm and panel block
// Assumes: 100 MHz clock, base tick averages 6 MHz
// Notes: pwm counts allow a few cycles for the 16/17 tick jitter
`timescale 1ns/1ns
module dual_pwm_and_panel_enables_tb;
    logic mclk_i, nrst_i, reg_ofs_wr_i, reg_wr_i, reg_rd_i, pwm0_o, pwm1_o, bl_o, pn_o;
    logic [7:0] reg_data_i, reg_rdata_o, r0, r1;
    logic [15:0] hi0, per0, hi1, per1;
    logic [7:0] ofs [6] = '{8'h4B, 8'h4C, 8'h4D, 8'h4E, 8'h51, 8'h52};
    int mismatches, n_tests;
    dual_pwm_and_panel_enables dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .reg_ofs_wr_i(reg_ofs_wr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_data_i(reg_data_i), .reg_rdata_o(reg_rdata_o),
        .pwm0_o(pwm0_o), .pwm1_o(pwm1_o), .backlight_enable_pin_o(bl_o), .panel_enable_pin_o(pn_o));
    pwm_probe p0_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .pwm_i(pwm0_o), .hi_o(hi0), .per_o(per0), .rises_o(r0));
    pwm_probe p1_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .pwm_i(pwm1_o), .hi_o(hi1), .per_o(per1), .rises_o(r1));
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    task report_and_stop;
        if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [15:0] g, input int lo, input int hi);
        n_tests++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: %0d not in %0d..%0d", $time, g, lo, hi);
        end
    endtask
    task wr(input logic [7:0] o, input logic [7:0] d);
        @(posedge mclk_i) {reg_ofs_wr_i, reg_data_i} <= {1'b1, o};
        @(posedge mclk_i) {reg_ofs_wr_i, reg_wr_i, reg_data_i} <= {2'b01, d};
        @(posedge mclk_i) reg_wr_i <= 1'b0;
        @(posedge mclk_i);
        @(negedge mclk_i);
    endtask
    task rd(input logic [7:0] o, input logic [7:0] e);
        @(posedge mclk_i) {reg_ofs_wr_i, reg_data_i} <= {1'b1, o};
        @(posedge mclk_i) {reg_ofs_wr_i, reg_rd_i} <= 2'b01;
        @(posedge mclk_i) reg_rd_i <= 1'b0;
        @(negedge mclk_i) chk({8'h00, reg_rdata_o}, e, e);
    endtask
    task wait_rise(input logic ch, input int n);
        int b;
        b = ch ? r1 : r0;
        for (int k = 0; k < 40000 && (ch ? r1 : r0) - b < n; k++) @(posedge mclk_i);
    endtask
    // a period is 256 prescaled ticks of (div+1) base ticks, each 100/6 clocks
    task per_chk(input logic ch, input int d, input int duty);
        chk(ch ? per1 : per0, 25600 * (d + 1) / 6 - 8, 25600 * (d + 1) / 6 + 8);
        chk(ch ? hi1 : hi0, duty * (d + 1) * 100 / 6 - 8, duty * (d + 1) * 100 / 6 + 8);
    endtask
    initial begin
        {nrst_i, reg_ofs_wr_i, reg_wr_i, reg_rd_i, reg_data_i} = '0;
        mismatches = 0;
        n_tests = 0;
        repeat (5) @(posedge mclk_i);
        nrst_i <= 1'b1;
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        chk({14'h0000, bl_o, pn_o}, 0, 0);
        wr(8'h51, 8'hFF);
        chk({15'h0000, bl_o}, 1, 1);
        rd(8'h51, 8'h01);
        wr(8'h52, 8'h01);
        chk({15'h0000, pn_o}, 1, 1);
        wr(8'h51, 8'h00);
        chk({15'h0000, bl_o}, 0, 0);
        rd(8'h50, 8'h00);
        rd(8'h52, 8'h01);
        wr(8'h4D, 8'h80);
        wr(8'h4C, 8'h80);
        wait_rise(1'b1, 2);
        per_chk(1'b1, 0, 128);
        wr(8'h4D, 8'h40);
        wait_rise(1'b1, 3);
        per_chk(1'b1, 0, 64);
        wr(8'h4C, 8'h00); // host stops the channel before retiming it
        // hold it off past one base tick so the stop really reaches the counters
        repeat (20) @(negedge mclk_i);
        chk({15'h0000, pwm1_o}, 0, 0);
        wr(8'h4C, 8'h81);
        wait_rise(1'b1, 2);
        per_chk(1'b1, 1, 64);
        wr(8'h4E, 8'h00);
        wr(8'h4B, 8'h80);
        repeat (9000) @(negedge mclk_i);
        chk({8'h00, r0}, 0, 0);
        wr(8'h4E, 8'hFF);
        wait_rise(1'b0, 2);
        per_chk(1'b0, 0, 255);
        rd(8'h4B, 8'h80);
        wr(8'h4B, 8'h00);
        repeat (40) @(negedge mclk_i);
        chk({15'h0000, pwm0_o}, 0, 0);
        report_and_stop;
    end
    initial begin
        #900000;
        mismatches++;
        report_and_stop;
    end
endmodule
